// ### dv/trgr_card_model.sv
// Another card sharing the eight backplane trigger lines.
// Assumes the router drives its lines registered on clk.
module trgr_card_model #(
  parameter int WATCH = 1
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] designOut,
  input  wire logic [7:0] designOe,
  input  wire logic [7:0] cardLvl,
  input  wire logic [7:0] cardOe,
  output logic [7:0]      line,
  output logic [3:0]      startCnt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic flip;
  logic prev;
  // Moving pattern for lines nobody drives
  always @(posedge clk)
  begin
    flip <= rst ? 1'b0 : ~flip;
  end
  // Wire level: router first, then this card, else the pattern
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      line[i] = designOe[i] ? designOut[i] : cardOe[i] ? cardLvl[i] : flip;
  end
  // Rises on the watched line while the router drives it are taken as a start indication
  always @(posedge clk)
  begin
    prev <= line[WATCH];
    if (rst)
      startCnt <= 4'h0;
    else if (line[WATCH] && !prev && designOe[WATCH])
      startCnt <= startCnt + 4'h1;
  end
endmodule // trgr_card_model

// ### dv/trgr_router_monitor.sv
// Port checks for the trigger and timebase source router.
// Assumes the default variant, with backplane and bus timing present.
module trgr_router_monitor (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic [trgr_pkg::SLOT_W-1:0]   slotNum,
  input wire trgr_pkg::trgr_req_s           req,
  input wire trgr_pkg::trgr_resp_s          resp,
  input wire logic [trgr_pkg::BP_LINES-1:0] bpTrigOe,
  input wire logic                          cycleStartIn,
  input wire logic [trgr_pkg::TS_W-1:0]     timestampCount,
  input wire logic [trgr_pkg::MT_W-1:0]     cycleMacrotick
);
  // ==========================================================
  // Clock, reset and helpers
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic live;
  // A connect request, as opposed to a disconnect
  assign live = req.valid && !req.disconnect;

  // ==========================================================
  // Answers to requests
  sequence s_acc;
    ##1 resp.accept;
  endsequence
  sequence s_rej;
    ##1 resp.reject;
  endsequence
  sequence s_bp_acc;
    live && req.dst == trgr_pkg::DST_BP_TRIG ##1 resp.accept;
  endsequence
  property p_resp;
    resp.accept || resp.reject |->
      $past(req.valid) && !(resp.accept && resp.reject);
  endproperty
  a_resp: assert property (p_resp) else $error("stray answer");
  property p_bad_dst;
    live && req.dst > trgr_pkg::DST_CARD_TIMEBASE_SELECT |-> s_rej;
  endproperty
  a_bad_dst: assert property (p_bad_dst) else $error("bad dst");
  property p_clk10;
    live && req.src == trgr_pkg::SRC_BP_CLK10 &&
      req.dst != trgr_pkg::DST_CARD_TIMEBASE_SELECT |-> s_rej;
  endproperty
  a_clk10: assert property (p_clk10) else $error("clk10 routed");
  property p_osc;
    live && req.src == trgr_pkg::SRC_LOCAL_1MHZ_OSC &&
      req.dst != trgr_pkg::DST_BP_TRIG |-> s_rej;
  endproperty
  a_osc: assert property (p_osc) else $error("osc routed");
  property p_star;
    live && req.src == trgr_pkg::SRC_STAR && req.dst == trgr_pkg::DST_START
      && slotNum >= trgr_pkg::STAR_MIN_SLOT |-> s_acc;
  endproperty
  a_star: assert property (p_star) else $error("star refused");
  property p_mt;
    live && req.src == trgr_pkg::SRC_BUS_MACROTICK && req.dst inside
      {trgr_pkg::DST_BP_TRIG, trgr_pkg::DST_FRONT_TRIGGER_A,
       trgr_pkg::DST_FRONT_TRIGGER_B} |-> s_acc;
  endproperty
  a_mt: assert property (p_mt) else $error("macrotick refused");
  property p_oe;
    s_bp_acc |=> bpTrigOe[$past(req.dstIdx, 2)];
  endproperty
  a_oe: assert property (p_oe) else $error("line not driven");

  // ==========================================================
  // Counters
  property p_cyc;
    cycleStartIn |=> cycleMacrotick == '0;
  endproperty
  a_cyc: assert property (p_cyc) else $error("count not cleared");
  property p_ts;
    $changed(timestampCount) |->
      timestampCount == $past(timestampCount) + 1'b1;
  endproperty
  a_ts: assert property (p_ts) else $error("timestamp jump");
endmodule // trgr_router_monitor

bind trgr_router trgr_router_monitor trgr_router_monitor_i (
  .clk(clk), .rst(rst), .slotNum(slotNum), .req(req), .resp(resp),
  .bpTrigOe(bpTrigOe), .cycleStartIn(cycleStartIn),
  .timestampCount(timestampCount), .cycleMacrotick(cycleMacrotick));

// ### dv/trgr_router_tb.sv
// Self-checking bench for the trigger and timebase source router.
// Assumes the monitor is bound and the card model shares the lines.
module trgr_router_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [3:0] s;
    logic [2:0] si;
    logic [2:0] d;
    logic [2:0] di;
    logic       acc;
  } trgr_row_s;
  // ==========================================================
  // Request table: source, index, destination, index, accepted
  localparam trgr_row_s ROWS [17] = '{
    '{4'h0, 3'h7, 3'h3, 3'h0, 1'b1}, '{4'h0, 3'h0, 3'h4, 3'h0, 1'b1},
    '{4'h1, 3'h0, 3'h3, 3'h0, 1'b1}, '{4'h2, 3'h0, 3'h4, 3'h0, 1'b1},
    '{4'h3, 3'h0, 3'h3, 3'h0, 1'b1}, '{4'h3, 3'h0, 3'h0, 3'h2, 1'b0},
    '{4'h4, 3'h0, 3'h4, 3'h0, 1'b1}, '{4'h4, 3'h0, 3'h0, 3'h2, 1'b0},
    '{4'h5, 3'h0, 3'h2, 3'h0, 1'b1}, '{4'h6, 3'h0, 3'h0, 3'h1, 1'b1},
    '{4'h6, 3'h0, 3'h3, 3'h0, 1'b0}, '{4'h7, 3'h0, 3'h1, 3'h0, 1'b1},
    '{4'h8, 3'h0, 3'h0, 3'h6, 1'b1}, '{4'h8, 3'h0, 3'h1, 3'h0, 1'b1},
    '{4'h9, 3'h0, 3'h2, 3'h0, 1'b0}, '{4'h9, 3'h0, 3'h0, 3'h7, 1'b1},
    '{4'h0, 3'h0, 3'h5, 3'h0, 1'b0}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  trgr_pkg::trgr_req_s   req = '0;
  trgr_pkg::trgr_resp_s  resp;
  trgr_pkg::trgr_route_s tbSel;
  logic [7:0]  line, bpOut, bpOe, cardOe = 8'h08, cardLvl = 8'h00;
  logic [1:0]  frontOut, frontOe, frontIn = 2'h0;
  logic        ifStart = 1'b0, ifStop = 1'b0, ifComm = 1'b0;
  logic        cycStart = 1'b0, mtIn = 1'b0, startTrig, lvl;
  logic [31:0] ts, ts0;
  logic [15:0] cycMt;
  logic [3:0]  startCnt;
  int          checked = 0;
  int          n_mismatch = 0;
  int          i;
  always #2 clk = ~clk;
  // ==========================================================
  // Router and the other card on the backplane
  trgr_router trgr_router_i (.clk(clk), .rst(rst), .slotNum(4'h5),
    .req(req), .resp(resp), .bpTrigIn(line), .bpTrigOut(bpOut),
    .bpTrigOe(bpOe), .frontIn(frontIn), .frontOut(frontOut),
    .frontOe(frontOe), .starIn(1'b0), .clk10In(1'b0),
    .ifStartPulse(ifStart), .ifStopPulse(ifStop),
    .ifCommunicating(ifComm), .cycleStartIn(cycStart),
    .macrotickIn(mtIn), .startTrigPulse(startTrig),
    .cardTimebaseSelect(tbSel), .timestampCount(ts),
    .cycleMacrotick(cycMt));
  trgr_card_model trgr_card_model_i (.clk(clk), .rst(rst),
    .designOut(bpOut), .designOe(bpOe), .cardLvl(cardLvl),
    .cardOe(cardOe), .line(line), .startCnt(startCnt));
  // ==========================================================
  // Shared tasks
  task automatic results;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input trgr_row_s r, input logic disc);
    req = '{1'b1, disc, trgr_pkg::trgr_src_e'(r.s), r.si,
            trgr_pkg::trgr_dst_e'(r.d), r.di};
    cyc(1);
    req.valid = 1'b0;
    chk(resp.accept === r.acc && resp.reject === !r.acc, "answer");
    cyc(1);
  endtask
  task automatic mt;
    mtIn = 1'b1;
    cyc(2);
    mtIn = 1'b0;
    cyc(2);
  endtask
  // Watchdog against a hang
  initial
  begin
    #40000;
    n_mismatch++;
    results();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    cyc(12);
    rst = 1'b0;
    cyc(1);
    chk(resp === 2'b00 && bpOe === 8'h00 && tbSel === '0, "reset");
    foreach (ROWS[k])
      send(ROWS[k], 1'b0);
    lvl = bpOut[7];
    for (i = 0; i < 300 && bpOut[7] === lvl; i++)
      cyc(1);
    chk(bpOe[7] === 1'b1 && i < 300, "osc line");
    send('{4'h0, 3'h0, 3'h0, 3'h7, 1'b1}, 1'b1);
    chk(bpOe[7] === 1'b0, "disconnect");
    ifStart = 1'b1;
    cyc(1);
    ifStart = 1'b0;
    cyc(3);
    chk(frontOut[1] === 1'b1 && frontOe[1] === 1'b1, "start evt");
    ifStop = 1'b1;
    cyc(1);
    ifStop = 1'b0;
    cyc(3);
    chk(frontOut[1] === 1'b0, "stop evt");
    send('{4'h0, 3'h3, 3'h3, 3'h0, 1'b1}, 1'b0);
    cardLvl[3] = 1'b1;
    for (i = 0; i < 4 && startTrig !== 1'b1; i++)
      cyc(1);
    chk(i < 4, "start pulse");
    send('{4'h1, 3'h0, 3'h3, 3'h0, 1'b1}, 1'b0);
    frontIn[0] = 1'b1;
    for (i = 0; i < 4 && startTrig !== 1'b1; i++)
      cyc(1);
    chk(i < 4, "front start");
    send('{4'h8, 3'h0, 3'h4, 3'h0, 1'b1}, 1'b0);
    chk(tbSel === trgr_pkg::trgr_route_s'{1'b1,
        trgr_pkg::SRC_BUS_MACROTICK, 3'h0}, "tb");
    send('{4'h4, 3'h0, 3'h0, 3'h3, 1'b0}, 1'b0);
    chk(tbSel.src === trgr_pkg::SRC_BUS_MACROTICK, "kept");
    ts0 = ts;
    mt();
    chk(ts === ts0, "mt idle");
    ifComm = 1'b1;
    cyc(4);
    chk(bpOut[1] === 1'b1 && startCnt === 4'h1, "comm evt");
    cycStart = 1'b1;
    cyc(1);
    cycStart = 1'b0;
    repeat (4) mt();
    cyc(2);
    chk(ts === ts0 + 32'h4 && cycMt === 16'h0004, "mt count");
    cycStart = 1'b1;
    cyc(1);
    cycStart = 1'b0;
    cyc(1);
    chk(cycMt === 16'h0000, "cycle clear");
    results();
  end
endmodule // trgr_router_tb

// ### hw/trgr_pkg.sv
// Constants and carrier types for the trigger and timebase source router.
// Assumes a single 250 MHz clock and synchronous trigger inputs.
//
// Operation
// RQ1 - Any of eight backplane lines is a source
// RQ2 - Either front trigger line is a source
// RQ3 - Star trigger usable only from slot three up
// RQ4 - No star or 10 MHz without backplane
// RQ5 - 10 MHz clock routes only to timebase
// RQ6 - One shared start event on start transition
// RQ7 - Shared event when interface becomes communicating
// RQ8 - Communicating event offered as alternate start
// RQ9 - Cycle start pulse output every bus cycle
// RQ10 - Macrotick valid only while communicating
// RQ11 - Macrotick routes to backplane or front outputs
// RQ12 - Macrotick timebase drives timestamps, cycle count readable
// RQ13 - Cycle start and macrotick need bus variant
// RQ14 - Local 1 MHz routes to backplane lines only
// RQ15 - Illegal pairings rejected, routing left untouched
package trgr_pkg;

  // ==========================================================
  // Sizes and timing
  localparam int BP_LINES      = 8;
  localparam int FRONT_LINES   = 2;
  localparam int STAR_MIN_SLOT = 3;
  localparam int SLOT_W        = 4;
  localparam int CLK_FREQ_HZ   = 250_000_000;
  localparam int OSC_FREQ_HZ   = 1_000_000;
  localparam int OSC_HALF_CYC  = CLK_FREQ_HZ / (2 * OSC_FREQ_HZ);
  localparam int OSC_CNT_W     = 8;
  localparam int TS_W          = 32;
  localparam int MT_W          = 16;

  localparam logic [OSC_CNT_W-1:0] OSC_LAST =
    OSC_CNT_W'(OSC_HALF_CYC - 1);

  // ==========================================================
  // Source and destination codes
  typedef enum logic [3:0] {
    SRC_BP_TRIG             = 4'h0,
    SRC_FRONT_TRIGGER_A     = 4'h1,
    SRC_FRONT_TRIGGER_B     = 4'h2,
    SRC_STAR                = 4'h3,
    SRC_BP_CLK10            = 4'h4,
    SRC_IF_START_EVENT      = 4'h5,
    SRC_COMMUNICATING_EVENT = 4'h6,
    SRC_CYCLE_START_PULSE   = 4'h7,
    SRC_BUS_MACROTICK       = 4'h8,
    SRC_LOCAL_1MHZ_OSC      = 4'h9
  } trgr_src_e;

  typedef enum logic [2:0] {
    DST_BP_TRIG              = 3'h0,
    DST_FRONT_TRIGGER_A      = 3'h1,
    DST_FRONT_TRIGGER_B      = 3'h2,
    DST_START                = 3'h3,
    DST_CARD_TIMEBASE_SELECT = 3'h4
  } trgr_dst_e;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic      on;
    trgr_src_e src;
    logic [2:0] idx;
  } trgr_route_s;

  typedef struct packed {
    logic       valid;
    logic       disconnect;
    trgr_src_e  src;
    logic [2:0] srcIdx;
    trgr_dst_e  dst;
    logic [2:0] dstIdx;
  } trgr_req_s;

  typedef struct packed {
    logic accept;
    logic reject;
  } trgr_resp_s;

  typedef struct packed {
    logic                    strapDone;
    logic [SLOT_W-1:0]       slot;
    trgr_route_s [BP_LINES-1:0]    bpRoute;
    trgr_route_s [FRONT_LINES-1:0] frontRoute;
    trgr_route_s             startRoute;
    trgr_route_s             tbRoute;
    logic [OSC_CNT_W-1:0]    oscCnt;
    logic                    oscLvl;
    logic                    startEvt;
    logic                    commEvt;
    logic                    mtPrev;
    logic                    startPrev;
    logic                    tbPrev;
    logic [TS_W-1:0]         ts;
    logic [MT_W-1:0]         cycleMt;
    trgr_resp_s              resp;
    logic [BP_LINES-1:0]     bpOut;
    logic [BP_LINES-1:0]     bpOe;
    logic [FRONT_LINES-1:0]  frontOut;
    logic [FRONT_LINES-1:0]  frontOe;
    logic                    startTrig;
  } trgr_state_s;

endpackage

// ### hw/trgr_router.sv
// Source side of the trigger and timebase routing matrix.
// Assumes all trigger inputs are synchronous to clk and that the
// surrounding pad logic resolves the backplane and front line wires
// from the output enables.
module trgr_router #(
  parameter bit HAS_BACKPLANE = 1'b1,
  parameter bit IS_FLEXRAY    = 1'b1
) (
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire logic [trgr_pkg::SLOT_W-1:0]         slotNum,
  input  wire trgr_pkg::trgr_req_s                 req,
  output trgr_pkg::trgr_resp_s                     resp,
  input  wire logic [trgr_pkg::BP_LINES-1:0]       bpTrigIn,
  output logic [trgr_pkg::BP_LINES-1:0]            bpTrigOut,
  output logic [trgr_pkg::BP_LINES-1:0]            bpTrigOe,
  input  wire logic [trgr_pkg::FRONT_LINES-1:0]    frontIn,
  output logic [trgr_pkg::FRONT_LINES-1:0]         frontOut,
  output logic [trgr_pkg::FRONT_LINES-1:0]         frontOe,
  input  wire logic                                starIn,
  input  wire logic                                clk10In,
  input  wire logic                                ifStartPulse,
  input  wire logic                                ifStopPulse,
  input  wire logic                                ifCommunicating,
  input  wire logic                                cycleStartIn,
  input  wire logic                                macrotickIn,
  output logic                                     startTrigPulse,
  output trgr_pkg::trgr_route_s                    cardTimebaseSelect,
  output logic [trgr_pkg::TS_W-1:0]                timestampCount,
  output logic [trgr_pkg::MT_W-1:0]                cycleMacrotick
);

  // ==========================================================
  // Elaboration checks
  if (trgr_pkg::OSC_HALF_CYC < 1)
  begin : gChkOsc
    $error("Clock too slow for the local 1 MHz source");
  end
  if (trgr_pkg::OSC_HALF_CYC > (1 << trgr_pkg::OSC_CNT_W))
  begin : gChkOscW
    $error("Oscillator counter too narrow");
  end
  // Route and request indices are three bits wide
  if (trgr_pkg::BP_LINES > 8)
  begin : gChkBp
    $error("Too many backplane lines for a three bit index");
  end
  // Front destinations are decoded as two fixed codes, A and B
  if (trgr_pkg::FRONT_LINES != 2)
  begin : gChkFront
    $error("Front destination codes serve exactly two lines");
  end

  // ==========================================================
  // State
  trgr_pkg::trgr_state_s state_ff;
  trgr_pkg::trgr_state_s nxt_state;
  logic                  mtLvl;
  logic                  cycLvl;
  logic                  tbLvl;
  logic                  startLvl;

  // Macrotick only exists on the bus variant and once communicating
  assign mtLvl  = IS_FLEXRAY & ifCommunicating & macrotickIn; // RQ10
  assign cycLvl = IS_FLEXRAY & cycleStartIn; // RQ13

  // ==========================================================
  // Level of a routed source
  function automatic logic srcLevel(trgr_pkg::trgr_route_s r);
    logic lvl;
    lvl = 1'b0;
    unique case (r.src)
      trgr_pkg::SRC_BP_TRIG:             lvl = bpTrigIn[r.idx]; // RQ1
      trgr_pkg::SRC_FRONT_TRIGGER_A:     lvl = frontIn[0]; // RQ2
      trgr_pkg::SRC_FRONT_TRIGGER_B:     lvl = frontIn[1]; // RQ2
      trgr_pkg::SRC_STAR:                lvl = HAS_BACKPLANE & starIn;
      trgr_pkg::SRC_BP_CLK10:            lvl = HAS_BACKPLANE & clk10In;
      trgr_pkg::SRC_IF_START_EVENT:      lvl = state_ff.startEvt; // RQ6
      trgr_pkg::SRC_COMMUNICATING_EVENT: lvl = state_ff.commEvt; // RQ7
      trgr_pkg::SRC_CYCLE_START_PULSE:   lvl = cycLvl; // RQ9
      trgr_pkg::SRC_BUS_MACROTICK:       lvl = mtLvl; // RQ10
      trgr_pkg::SRC_LOCAL_1MHZ_OSC:      lvl = state_ff.oscLvl;
      default:                           lvl = 1'b0;
    endcase
    return r.on & lvl;
  endfunction

  // ==========================================================
  // Allowed pairing of source and destination
  function automatic logic pairOk(trgr_pkg::trgr_src_e s,
                                  trgr_pkg::trgr_dst_e d,
                                  logic [trgr_pkg::SLOT_W-1:0] slot);
    logic toLine;
    logic ok;
    toLine = (d == trgr_pkg::DST_BP_TRIG) ||
             (d == trgr_pkg::DST_FRONT_TRIGGER_A) ||
             (d == trgr_pkg::DST_FRONT_TRIGGER_B);
    ok = 1'b0;
    unique case (s)
      trgr_pkg::SRC_BP_TRIG,
      trgr_pkg::SRC_FRONT_TRIGGER_A,
      trgr_pkg::SRC_FRONT_TRIGGER_B:
        ok = (d == trgr_pkg::DST_START) ||
             (d == trgr_pkg::DST_CARD_TIMEBASE_SELECT); // RQ1 RQ2
      trgr_pkg::SRC_STAR:
        ok = HAS_BACKPLANE && (d == trgr_pkg::DST_START) &&
             (slot >= trgr_pkg::SLOT_W'(trgr_pkg::STAR_MIN_SLOT)); // RQ3 RQ4
      trgr_pkg::SRC_BP_CLK10:
        ok = HAS_BACKPLANE &&
             (d == trgr_pkg::DST_CARD_TIMEBASE_SELECT); // RQ4 RQ5
      trgr_pkg::SRC_IF_START_EVENT:
        ok = toLine; // RQ6
      trgr_pkg::SRC_COMMUNICATING_EVENT:
        ok = toLine; // RQ8
      trgr_pkg::SRC_CYCLE_START_PULSE:
        ok = IS_FLEXRAY && toLine; // RQ9 RQ13
      trgr_pkg::SRC_BUS_MACROTICK:
        ok = IS_FLEXRAY && (toLine ||
             (d == trgr_pkg::DST_CARD_TIMEBASE_SELECT)); // RQ11 RQ13
      trgr_pkg::SRC_LOCAL_1MHZ_OSC:
        ok = (d == trgr_pkg::DST_BP_TRIG); // RQ14
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ==========================================================
  // Destination code within range
  function automatic logic dstOk(trgr_pkg::trgr_dst_e d);
    return (d == trgr_pkg::DST_BP_TRIG) ||
           (d == trgr_pkg::DST_FRONT_TRIGGER_A) ||
           (d == trgr_pkg::DST_FRONT_TRIGGER_B) ||
           (d == trgr_pkg::DST_START) ||
           (d == trgr_pkg::DST_CARD_TIMEBASE_SELECT);
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    trgr_pkg::trgr_route_s newRoute;
    logic                  doWrite;
    newRoute  = '0;
    doWrite   = 1'b0;
    nxt_state = state_ff;
    nxt_state.resp = '0;

    // Slot strap taken once, just after reset release
    if (!state_ff.strapDone)
    begin
      nxt_state.slot      = slotNum;
      nxt_state.strapDone = 1'b1;
    end

    // Local 1 MHz square wave from the system clock
    if (state_ff.oscCnt == trgr_pkg::OSC_LAST)
    begin
      nxt_state.oscCnt = '0;
      nxt_state.oscLvl = ~state_ff.oscLvl;
    end
    else
    begin
      nxt_state.oscCnt = state_ff.oscCnt + 1'b1;
    end

    // Shared start event, start wins over a coincident stop
    if (ifStopPulse)
    begin
      nxt_state.startEvt = 1'b0;
    end
    if (ifStartPulse)
    begin
      nxt_state.startEvt = 1'b1; // RQ6
    end

    // Communicating event rises on entry to communicating
    nxt_state.commEvt = ifCommunicating; // RQ7

    // Macrotick count within the current cycle
    nxt_state.mtPrev = mtLvl;
    if (cycLvl)
    begin
      nxt_state.cycleMt = '0; // RQ12
    end
    else if (mtLvl && !state_ff.mtPrev)
    begin
      nxt_state.cycleMt = state_ff.cycleMt + 1'b1; // RQ12
    end

    // Connect and disconnect requests
    if (req.valid)
    begin
      if (!dstOk(req.dst))
      begin
        nxt_state.resp.reject = 1'b1; // RQ15
      end
      else if (req.disconnect)
      begin
        doWrite = 1'b1;
        nxt_state.resp.accept = 1'b1;
      end
      else if (pairOk(req.src, req.dst, state_ff.slot))
      begin
        newRoute.on  = 1'b1;
        newRoute.src = req.src;
        newRoute.idx = req.srcIdx;
        doWrite      = 1'b1;
        nxt_state.resp.accept = 1'b1;
      end
      else
      begin
        nxt_state.resp.reject = 1'b1; // RQ15
      end
    end

    // Store the route at its destination
    if (doWrite)
    begin
      unique case (req.dst)
        trgr_pkg::DST_BP_TRIG:
          nxt_state.bpRoute[req.dstIdx] = newRoute;
        trgr_pkg::DST_FRONT_TRIGGER_A:
          nxt_state.frontRoute[0] = newRoute;
        trgr_pkg::DST_FRONT_TRIGGER_B:
          nxt_state.frontRoute[1] = newRoute;
        trgr_pkg::DST_START:
          nxt_state.startRoute = newRoute;
        trgr_pkg::DST_CARD_TIMEBASE_SELECT:
          nxt_state.tbRoute = newRoute; // RQ5
        default:
          nxt_state.tbRoute = state_ff.tbRoute;
      endcase
    end

    // Drive routed sources onto the trigger lines
    for (int i = 0; i < trgr_pkg::BP_LINES; i++)
    begin
      nxt_state.bpOut[i] = srcLevel(state_ff.bpRoute[i]); // RQ11 RQ14
      nxt_state.bpOe[i]  = state_ff.bpRoute[i].on;
    end
    for (int i = 0; i < trgr_pkg::FRONT_LINES; i++)
    begin
      nxt_state.frontOut[i] = srcLevel(state_ff.frontRoute[i]); // RQ11
      nxt_state.frontOe[i]  = state_ff.frontRoute[i].on;
    end

    // Start request on rising edge of the routed start source
    nxt_state.startPrev = startLvl;
    nxt_state.startTrig = startLvl & ~state_ff.startPrev;

    // Timestamp counter ticks on the selected timebase
    nxt_state.tbPrev = tbLvl;
    if (tbLvl && !state_ff.tbPrev)
    begin
      nxt_state.ts = state_ff.ts + 1'b1; // RQ12
    end
  end

  // Start source and timebase levels, timebase on local 1 MHz by default.
  // Kept in a process: the level function reads the line inputs
  // directly, and a continuous assignment would only wake up on a
  // change of its route argument, lagging the lines by a cycle.
  always_comb
  begin
    startLvl = srcLevel(state_ff.startRoute);
    if (state_ff.tbRoute.on)
    begin
      tbLvl = srcLevel(state_ff.tbRoute); // RQ5 RQ12
    end
    else
    begin
      tbLvl = state_ff.oscLvl;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign resp               = state_ff.resp;
  assign bpTrigOut          = state_ff.bpOut;
  assign bpTrigOe           = state_ff.bpOe;
  assign frontOut           = state_ff.frontOut;
  assign frontOe            = state_ff.frontOe;
  assign startTrigPulse     = state_ff.startTrig;
  assign cardTimebaseSelect = state_ff.tbRoute;
  assign timestampCount     = state_ff.ts;
  assign cycleMacrotick     = state_ff.cycleMt;

endmodule // trgr_router
